// ==== rss_strap_map.vh ====
// constants for the repeater status, strap and mode pin block
`ifndef RSS_STRAP_MAP_VH
`define RSS_STRAP_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RSS_OFF_CTRL 4'h0
`define RSS_OFF_STATUS 4'h1
`define RSS_OFF_IRQ_STAT 4'h2
`define RSS_OFF_IRQ_EN 4'h3
`define RSS_OFF_IRQ_CLR 4'h4
`define RSS_OFF_ID 4'h5

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RSS_CTRL_ID_FAULT_BIT 0
`define RSS_IRQ_W 3
`define RSS_IRQ_IDF_BIT 0
`define RSS_IRQ_MODE_BIT 1
`define RSS_IRQ_WRAP_BIT 2
`define RSS_IRQ_EN_RST 3'h0
`define RSS_ID_VALUE 16'h0A5C

// ----------------------------------------------------------------
// state indicator codes
// ----------------------------------------------------------------
`define RSS_ST_IDLE 4'h0
`define RSS_ST_COLL 4'h1
`define RSS_ST_ONE_LEFT 4'h2
`define RSS_ST_REPEAT 4'h3
`define RSS_ST_NOISE 4'h4

// ----------------------------------------------------------------
// mode pin codes and scan timing
// ----------------------------------------------------------------
`define RSS_MODE_NORMAL 2'b00
`define RSS_MODE_TEST_A 2'b10
`define RSS_MODE_TEST_B 2'b01
`define RSS_MODE_PREAMBLE 2'b11
`define RSS_PORTS 12
`define RSS_LAST_PORT 4'hB
`define RSS_SCAN_STEP_NS 1000
`define RSS_CLK_NS 10
`define RSS_SCAN_STEP_CYC (`RSS_SCAN_STEP_NS / `RSS_CLK_NS)
`define RSS_PRE_NIBBLES 15
`define RSS_NIB_PRE 4'h5
`define RSS_NIB_SFD 4'hD

`endif

// ==== rss_sync2.v ====
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module rss_sync2 #(
   parameter W = 1
) (
   input wire core_clk,
   input wire resetn,
   input wire clkEn,
   input wire [W-1:0] asyncIn,
   output reg [W-1:0] syncOut
);
   reg [W-1:0] stage1_reg;

   // first stage feeds only the second stage
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage1_reg <= {W{1'b0}};
         syncOut <= {W{1'b0}};
      end else if (clkEn) begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end
endmodule // rss_sync2

// ==== rss_status_strap.v ====
// status scan, identity fault, strap capture and mode decode
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "rss_strap_map.vh"

// Behaviour
// RQ1 - scan port number 0 to 11 repeatedly
// RQ2 - scan bit four shows partition
// RQ3 - scan bit five shows jabber
// RQ4 - fault pin follows identity fault flag
// RQ5 - strap pin is input, sampled in reset; code samples it just after release while the driver is still off
// RQ6 - strap high active high, low active low
// RQ7 - after reset pin drives indicator bit three
// RQ8 - indicator codes idle 0 coll 1 ...
// RQ9 - mode 00 normal, 10/01 test
// RQ10 - mode 11 selects preamble regeneration
// RQ11 - receive enable only for single active port; until strap latch all are held low, so all asserted for a low strap
// RQ12 - full preamble 15x5 then D, despite collision
// RQ13 - scan flags change with port number
// RQ14 - strap driver off in reset, latched after
module rss_status_strap #(
   parameter PORTS = `RSS_PORTS,
   parameter SCAN_STEP = `RSS_SCAN_STEP_CYC
) (
   input wire core_clk,
   input wire resetn,
   input wire clkEn,
   input wire [3:0] regAddr,
   input wire [15:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [15:0] regRdata,
   input wire [PORTS-1:0] partitionIn,
   input wire [PORTS-1:0] jabberIn,
   input wire [PORTS-1:0] rxActive,
   input wire idFaultFlag,
   input wire [2:0] rsmState,
   input wire preambleStart,
   input wire [1:0] modePins,
   input wire strapPinIn,
   output reg strapPinOut,
   output reg strapPinOe,
   output reg [2:0] stateIndicatorLow,
   output reg [5:0] portStatusScan,
   output reg idFaultOut,
   output reg [PORTS-1:0] portReceiveEnable,
   output reg preambleActive,
   output reg [3:0] preambleNibble,
   output reg modePreamble,
   output reg modeTest,
   output reg irq
);
   // ----------------------------------------------------------------
   // state declarations
   // ----------------------------------------------------------------
   localparam PS_IDLE = 2'd0;
   localparam PS_PRE = 2'd1;
   localparam PS_SFD = 2'd2;

   wire [PORTS-1:0] partSync;
   wire [PORTS-1:0] jabSync;
   wire [PORTS-1:0] rxSync;
   wire [1:0] modeSync;
   wire strapSync;
   reg strapSeen_reg;
   reg rxPolHigh_reg;
   reg [1:0] rstRelease_reg;
   reg [15:0] scanDiv_reg;
   reg [3:0] scanPort_reg;
   reg [3:0] scanPortNext;
   reg [2:0] irqStat_reg;
   reg [2:0] irqEn_reg;
   reg [1:0] modeLast_reg;
   reg [1:0] preState_reg;
   reg [3:0] preCount_reg;
   reg [PORTS-1:0] rxEnNext;
   reg [3:0] activeCount;
   reg [3:0] indicatorNext;
   reg [2:0] irqEvent;
   integer i;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   rss_sync2 #(.W(3 * PORTS + 3)) uSync (
      .core_clk(core_clk),
      .resetn(resetn),
      .clkEn(clkEn),
      .asyncIn({partitionIn, jabberIn, rxActive, modePins, strapPinIn}),
      .syncOut({partSync, jabSync, rxSync, modeSync, strapSync})
   );

   // ----------------------------------------------------------------
   // strap capture and state indicator
   // ----------------------------------------------------------------
   // the reset flops take constants only, so the strap is caught by the
   // first clocked samples after release while the driver is still off
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rstRelease_reg <= 2'b00;
         strapSeen_reg <= 1'b0;
         rxPolHigh_reg <= 1'b1;
         strapPinOe <= 1'b0; // RQ14
      end else if (clkEn) begin
         rstRelease_reg <= {rstRelease_reg[0], 1'b1};
         // wait for the synchroniser to carry the reset-time pin level
         if (rstRelease_reg == 2'b11 && !strapSeen_reg) begin
            strapSeen_reg <= 1'b1;
            rxPolHigh_reg <= strapSync; // RQ5 RQ6 RQ14
            strapPinOe <= 1'b1; // RQ7
         end
      end
   end

   // map state machine encoding onto indicator codes
   always @* begin
      case (rsmState)
         3'd0: indicatorNext = `RSS_ST_IDLE; // RQ8
         3'd1: indicatorNext = `RSS_ST_COLL;
         3'd2: indicatorNext = `RSS_ST_ONE_LEFT;
         3'd3: indicatorNext = `RSS_ST_REPEAT;
         3'd4: indicatorNext = `RSS_ST_NOISE;
         default: indicatorNext = `RSS_ST_IDLE;
      endcase
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stateIndicatorLow <= 3'b000;
         strapPinOut <= 1'b0;
      end else if (clkEn) begin
         stateIndicatorLow <= indicatorNext[2:0];
         strapPinOut <= indicatorNext[3]; // RQ7
      end
   end

   // ----------------------------------------------------------------
   // port status scan
   // ----------------------------------------------------------------
   // next port in the scan, wrapping after the last port
   always @* begin
      if (scanPort_reg == `RSS_LAST_PORT) begin
         scanPortNext = 4'h0; // RQ1
      end else begin
         scanPortNext = scanPort_reg + 4'h1; // RQ1
      end
   end

   // slow step so an external decoder can follow; flags load only with the
   // port number, so a flag edge mid-step cannot show up beside a stale port
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         scanDiv_reg <= 16'h0000;
         scanPort_reg <= 4'h0;
         portStatusScan <= 6'h00;
      end else if (clkEn) begin
         if (scanDiv_reg >= SCAN_STEP[15:0] - 16'h0001) begin
            scanDiv_reg <= 16'h0000;
            scanPort_reg <= scanPortNext; // RQ1
            // all six bits from the same port index in one flop load
            portStatusScan <= {jabSync[scanPortNext], partSync[scanPortNext],
                               scanPortNext}; // RQ2 RQ3 RQ13
         end else begin
            scanDiv_reg <= scanDiv_reg + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // receive enable, identity fault, mode decode
   // ----------------------------------------------------------------
   always @* begin
      activeCount = 4'h0;
      for (i = 0; i < PORTS; i = i + 1) begin
         activeCount = activeCount + {3'b000, rxSync[i]};
      end
      // a collision enables no port at all
      if (activeCount == 4'h1) begin
         rxEnNext = rxSync; // RQ11
      end else begin
         rxEnNext = {PORTS{1'b0}}; // RQ11
      end
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         portReceiveEnable <= {PORTS{1'b0}};
         idFaultOut <= 1'b0;
         modePreamble <= 1'b0;
         modeTest <= 1'b0;
         modeLast_reg <= `RSS_MODE_NORMAL;
      end else if (clkEn) begin
         // until the strap is latched hold all receive enables low, whichever polarity follows
         if (!strapSeen_reg) begin
            portReceiveEnable <= {PORTS{1'b0}};
         end else if (rxPolHigh_reg) begin
            portReceiveEnable <= rxEnNext; // RQ6
         end else begin
            portReceiveEnable <= ~rxEnNext; // RQ6
         end
         idFaultOut <= idFaultFlag; // RQ4
         modeLast_reg <= modeSync;
         modePreamble <= (modeSync == `RSS_MODE_PREAMBLE); // RQ10
         modeTest <= (modeSync == `RSS_MODE_TEST_A) ||
                     (modeSync == `RSS_MODE_TEST_B); // RQ9
      end
   end

   // ----------------------------------------------------------------
   // preamble regeneration sequencer
   // ----------------------------------------------------------------
   // no collision input on purpose: once begun the preamble always completes
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         preState_reg <= PS_IDLE;
         preCount_reg <= 4'h0;
         preambleActive <= 1'b0;
         preambleNibble <= 4'h0;
      end else if (clkEn) begin
         case (preState_reg)
            PS_IDLE: begin
               preambleActive <= 1'b0;
               preambleNibble <= 4'h0;
               if (preambleStart && modePreamble) begin // RQ10
                  preState_reg <= PS_PRE;
                  preCount_reg <= 4'h1;
                  preambleActive <= 1'b1;
                  preambleNibble <= `RSS_NIB_PRE; // RQ12
               end
            end
            PS_PRE: begin
               if (preCount_reg == `RSS_PRE_NIBBLES) begin
                  preState_reg <= PS_SFD;
                  preambleNibble <= `RSS_NIB_SFD; // RQ12
               end else begin
                  preCount_reg <= preCount_reg + 4'h1;
                  preambleNibble <= `RSS_NIB_PRE; // RQ12
               end
            end
            PS_SFD: begin
               preState_reg <= PS_IDLE;
               preambleActive <= 1'b0;
               preambleNibble <= 4'h0;
            end
            default: begin
               preState_reg <= PS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupts and register port
   // ----------------------------------------------------------------
   always @* begin
      irqEvent = 3'b000;
      irqEvent[`RSS_IRQ_IDF_BIT] = idFaultFlag && !idFaultOut;
      irqEvent[`RSS_IRQ_MODE_BIT] = strapSeen_reg && (modeSync != modeLast_reg);
      irqEvent[`RSS_IRQ_WRAP_BIT] = (preState_reg == PS_SFD);
   end

   // set wins over a clear in the same cycle
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqStat_reg <= 3'b000;
         irqEn_reg <= `RSS_IRQ_EN_RST;
         irq <= 1'b0;
         regRdata <= 16'h0000;
      end else if (clkEn) begin
         if (regWr && regAddr == `RSS_OFF_IRQ_CLR) begin
            irqStat_reg <= (irqStat_reg & ~regWdata[2:0]) | irqEvent;
         end else begin
            irqStat_reg <= irqStat_reg | irqEvent;
         end
         if (regWr && regAddr == `RSS_OFF_IRQ_EN) begin
            irqEn_reg <= regWdata[2:0];
         end
         irq <= |(irqStat_reg & irqEn_reg);
         regRdata <= 16'h0000;
         if (regRd) begin
            case (regAddr)
               `RSS_OFF_STATUS: regRdata <= {5'h00, rxPolHigh_reg, modeSync,
                                             scanPort_reg, strapPinOut,
                                             stateIndicatorLow};
               `RSS_OFF_IRQ_STAT: regRdata <= {13'h0000, irqStat_reg};
               `RSS_OFF_IRQ_EN: regRdata <= {13'h0000, irqEn_reg};
               `RSS_OFF_ID: regRdata <= `RSS_ID_VALUE;
               `RSS_OFF_CTRL: regRdata <= {15'h0000, idFaultOut};
               default: regRdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule // rss_status_strap

// ==== rss_strap_pull.sv ====
// board strap resistor model for the shared indicator pin
`timescale 1ns/1ns
module rss_strap_pull (
   input wire pullHigh,
   input wire pinOut,
   input wire pinOe,
   output wire pinLevel
);
   // the resistor only wins while the device leaves the pin undriven
   assign pinLevel = pinOe ? pinOut : pullHigh;
endmodule // rss_strap_pull

// ==== rss_status_strap_assertions.sv ====
// concurrent checks on scan, fault, strap, mode and preamble pins
`timescale 1ns/1ns
module rss_status_strap_assertions #(
   parameter PORTS = 12
) (
   input wire core_clk,
   input wire resetn,
   input wire [5:0] portStatusScan,
   input wire idFaultFlag,
   input wire idFaultOut,
   input wire strapPinOe,
   input wire strapPinOut,
   input wire [1:0] modePins,
   input wire modeTest,
   input wire modePreamble,
   input wire [PORTS-1:0] portReceiveEnable,
   input wire preambleActive,
   input wire [3:0] preambleNibble
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // port number steps by one and wraps after the last port
   property p_scan_wrap;
      $changed(portStatusScan[3:0]) |-> portStatusScan[3:0] ==
         ($past(portStatusScan[3:0]) == 4'hB ? 4'h0 : $past(portStatusScan[3:0]) + 4'h1);
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan port out of order");
   // flags never move without the port number; early edges skip the first load
   property p_scan_together;
      $past(resetn, 8) && $changed(portStatusScan[5:4]) |-> $changed(portStatusScan[3:0]);
   endproperty
   a_scan_together: assert property (p_scan_together) else $error("scan flags moved alone");
   property p_fault;
      $past(resetn) |-> idFaultOut == $past(idFaultFlag);
   endproperty
   a_fault: assert property (p_fault) else $error("fault pin not following flag");
   property p_oe_reset;
      disable iff (1'b0) !resetn |-> !strapPinOe;
   endproperty
   a_oe_reset: assert property (p_oe_reset) else $error("strap pin driven in reset");
   property p_strap_out;
      strapPinOe |-> !strapPinOut;
   endproperty
   a_strap_out: assert property (p_strap_out) else $error("indicator bit three wrong");
   property p_mode_excl;
      !(modeTest && modePreamble);
   endproperty
   a_mode_excl: assert property (p_mode_excl) else $error("two modes at once");
   property p_mode_dec;
      ($stable(modePins) && $past(resetn, 4))[*4] |->
         modeTest == ^modePins && modePreamble == &modePins;
   endproperty
   a_mode_dec: assert property (p_mode_dec) else $error("mode decode wrong");
   property p_rx_single;
      strapPinOe |-> $countones(portReceiveEnable) <= 1 || $countones(~portReceiveEnable) <= 1;
   endproperty
   a_rx_single: assert property (p_rx_single) else $error("several receive enables");
   property p_pre;
      $rose(preambleActive) |-> (preambleActive && preambleNibble == 4'h5)[*8]
         ##1 (preambleActive && preambleNibble == 4'h5)[*7]
         ##1 (preambleActive && preambleNibble == 4'hD) ##1 !preambleActive;
   endproperty
   a_pre: assert property (p_pre) else $error("preamble sequence wrong");
endmodule // rss_status_strap_assertions

// ==== tb_top.sv ====
// self-checking bench for the status, strap and mode block
`timescale 1ns/1ns
`include "rss_strap_map.vh"
module tb_top;
   localparam STEP = 3;
   reg core_clk = 1'b0;
   reg resetn = 1'b0;
   reg [3:0] regAddr = 4'h0;
   reg [15:0] regWdata = 16'h0000;
   reg regWr = 1'b0, regRd = 1'b0, idFaultFlag = 1'b0, preambleStart = 1'b0, pullHigh = 1'b1;
   reg [11:0] partitionIn = 12'h000, jabberIn = 12'h000, rxActive = 12'h000;
   reg [2:0] rsmState = 3'h0;
   reg [1:0] modePins = 2'h0;
   wire strapPinIn, strapPinOut, strapPinOe, idFaultOut, preambleActive, modePreamble;
   wire modeTest, irq;
   wire [15:0] regRdata;
   wire [2:0] stateIndicatorLow;
   wire [5:0] portStatusScan;
   wire [11:0] portReceiveEnable;
   wire [3:0] preambleNibble;
   integer miscompares = 0, n_checks = 0;
   reg [15:0] rd;
   // short scan step keeps the wrap within a few dozen cycles
   rss_status_strap #(.PORTS(12), .SCAN_STEP(STEP)) rss_status_strap_inst (
      .core_clk(core_clk), .resetn(resetn), .clkEn(1'b1), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .partitionIn(partitionIn), .jabberIn(jabberIn), .rxActive(rxActive),
      .idFaultFlag(idFaultFlag), .rsmState(rsmState), .preambleStart(preambleStart),
      .modePins(modePins), .strapPinIn(strapPinIn), .strapPinOut(strapPinOut),
      .strapPinOe(strapPinOe), .stateIndicatorLow(stateIndicatorLow),
      .portStatusScan(portStatusScan), .idFaultOut(idFaultOut),
      .portReceiveEnable(portReceiveEnable), .preambleActive(preambleActive),
      .preambleNibble(preambleNibble), .modePreamble(modePreamble), .modeTest(modeTest),
      .irq(irq));
   rss_strap_pull rss_strap_pull_inst (.pullHigh(pullHigh), .pinOut(strapPinOut),
      .pinOe(strapPinOe), .pinLevel(strapPinIn));
   // free-running core clock
   always #5 core_clk = ~core_clk;
   // ----------------
   // shared tasks
   // ----------------
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task wait_n(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   task doReset(input p);
      begin
         @(posedge core_clk);
         resetn <= 1'b0;
         pullHigh <= p;
         repeat (8) @(posedge core_clk);
         resetn <= 1'b1;
         wait_n(4);
      end
   endtask
   // read data stand only in the cycle after the strobe
   task rdReg(input [3:0] a);
      begin
         @(posedge core_clk);
         regRd <= 1'b1;
         regAddr <= a;
         @(posedge core_clk);
         regRd <= 1'b0;
         #1 rd = regRdata;
      end
   endtask
   task wrReg(input [3:0] a, input [15:0] d);
      begin
         @(posedge core_clk);
         regWr <= 1'b1;
         regAddr <= a;
         regWdata <= d;
         @(posedge core_clk);
         regWr <= 1'b0;
      end
   endtask
   // ----------------
   // scenarios
   // ----------------
   task t_scan;
      integer i;
      begin
         @(posedge core_clk);
         partitionIn <= 12'h5A3;
         jabberIn <= 12'h3C6;
         wait_n(10 * STEP);
         for (i = 0; i < 15 * STEP; i = i + 1) begin
            chk("scan range", portStatusScan[3:0] > 4'hB, 1'b0);
            chk("scan flags", portStatusScan[5:4], {jabberIn[portStatusScan[3:0]],
               partitionIn[portStatusScan[3:0]]});
            wait_n(1);
         end
      end
   endtask
   task t_fault;
      begin
         @(posedge core_clk);
         idFaultFlag <= 1'b1;
         wait_n(3);
         chk("fault pin", idFaultOut, 1'b1);
         chk("irq masked", irq, 1'b0);
         rdReg(`RSS_OFF_CTRL);
         chk("ctrl fault", rd[0], 1'b1);
         wrReg(`RSS_OFF_IRQ_EN, 16'h0001);
         wait_n(2);
         chk("irq raised", irq, 1'b1);
         @(posedge core_clk);
         idFaultFlag <= 1'b0;
         wait_n(2);
         chk("fault pin low", idFaultOut, 1'b0);
         wrReg(`RSS_OFF_IRQ_CLR, 16'h0001);
         wait_n(2);
         chk("irq cleared", irq, 1'b0);
         rdReg(`RSS_OFF_ID);
         chk("id", rd, `RSS_ID_VALUE);
         rdReg(4'hF);
         chk("unmapped", rd, 16'h0000);
      end
   endtask
   task t_ind;
      integer c;
      begin
         for (c = 0; c < 5; c = c + 1) begin
            @(posedge core_clk);
            rsmState <= c[2:0];
            wait_n(3);
            chk("indicator", {strapPinOut, stateIndicatorLow}, c[3:0]);
         end
      end
   endtask
   task t_mode;
      integer m;
      begin
         for (m = 0; m < 4; m = m + 1) begin
            @(posedge core_clk);
            modePins <= m[1:0];
            wait_n(5);
            chk("test mode", modeTest, m == 1 || m == 2);
            chk("preamble mode", modePreamble, m == 3);
         end
      end
   endtask
   // a collision raised together with the preamble start must not cut it short
   task t_pre;
      integer i;
      begin
         @(posedge core_clk);
         preambleStart <= 1'b1;
         rsmState <= 3'h1;
         @(posedge core_clk);
         preambleStart <= 1'b0;
         #1;
         for (i = 0; i < 4 && preambleActive !== 1'b1; i = i + 1)
            wait_n(1);
         for (i = 0; i < 16; i = i + 1) begin
            chk("preamble", {preambleActive, preambleNibble}, i < 15 ? 5'h15 : 5'h1D);
            wait_n(1);
         end
         chk("preamble end", preambleActive, 1'b0);
         rdReg(`RSS_OFF_IRQ_STAT);
         chk("preamble event", rd[2], 1'b1);
      end
   endtask
   task t_rxe(input p);
      begin
         doReset(p);
         chk("strap driver", strapPinOe, 1'b1);
         @(posedge core_clk);
         rxActive <= 12'h010;
         wait_n(4);
         chk("single rx", portReceiveEnable, p ? 12'h010 : 12'hFEF);
         @(posedge core_clk);
         rxActive <= 12'h810;
         wait_n(4);
         chk("two rx", portReceiveEnable, p ? 12'h000 : 12'hFFF);
         rdReg(`RSS_OFF_STATUS);
         chk("status polarity", rd[10], p);
         @(posedge core_clk);
         rxActive <= 12'h000;
      end
   endtask
   // main sequence; the second reset comes in mid-run
   initial begin
      doReset(1'b1);
      t_scan;
      $display("scan test done");
      t_fault;
      $display("fault test done");
      t_ind;
      $display("indicator test done");
      t_mode;
      $display("mode test done");
      t_pre;
      $display("preamble test done");
      t_rxe(1'b0);
      t_rxe(1'b1);
      $display("receive enable test done");
      give_verdict;
   end
   // watchdog well beyond the expected run length
   initial begin
      #100000;
      miscompares = miscompares + 1;
      give_verdict;
   end
endmodule // tb_top
bind rss_status_strap rss_status_strap_assertions #(.PORTS(PORTS)) chk_inst (
   .core_clk(core_clk), .resetn(resetn), .portStatusScan(portStatusScan),
   .idFaultFlag(idFaultFlag), .idFaultOut(idFaultOut), .strapPinOe(strapPinOe),
   .strapPinOut(strapPinOut), .modePins(modePins), .modeTest(modeTest),
   .modePreamble(modePreamble), .portReceiveEnable(portReceiveEnable),
   .preambleActive(preambleActive), .preambleNibble(preambleNibble));
